// *** common/mcuic_pkg.sv ***
package mcuic_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PFLAG     = 8'h04;
  localparam logic [7:0] OFS_PEN       = 8'h08;
  localparam logic [7:0] OFS_PORT      = 8'h0c;
  localparam logic [7:0] OFS_CFG       = 8'h10;
  // irq_control_reg field positions
  localparam int BIT_GLB_EN = 7;
  localparam int BIT_GRP_EN = 6;
  localparam int BIT_T0IE  = 5;
  localparam int BIT_EDGIE = 4;
  localparam int BIT_PCIE  = 3;
  localparam int BIT_T0IF  = 2;
  localparam int BIT_EDGIF = 1;
  localparam int BIT_PCIF  = 0;
  // cfg register field: 1 = rising edge on the external pin
  localparam int BIT_EDGE_RISE = 0;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CFG  = 8'h01;
  // sources held in irq_control_reg, total source budget
  localparam int CORE_SRC_N = 3;
  localparam int MAX_SRC_N  = 9;
  localparam int PERIPH_N_DEF = 6;
  localparam int PORT_N     = 4;
  // vectoring
  localparam int PC_W = 13;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [1:0]  LAT_TICKS  = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // vectoring states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } mcuic_state_t;
endpackage

// *** core/mcuic_src_detect.sv ***
module mcuic_src_detect
  import mcuic_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rstn_in,
  input  wire logic              edge_pin_in,
  input  wire logic              edge_rise_in,
  input  wire logic [PORT_N-1:0] port_pins_in,
  input  wire logic [PORT_N-1:0] port_is_input_in,
  input  wire logic              port_latch_in,
  output logic                   edge_event_out,
  output logic                   mismatch_out,
  output logic [PORT_N-1:0]      port_latched_out
);
  logic              pin_prev_ff;
  logic [PORT_N-1:0] latched_ff;
  logic [PORT_N-1:0] diff_bits;

  // previous pin level and the port snapshot taken on each port access
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_prev_ff <= 1'b0;
      latched_ff  <= '0;
    end else begin
      pin_prev_ff <= edge_pin_in;
      if (port_latch_in) begin
        latched_ff <= port_pins_in;
      end
    end
  end

  // selected edge of the external pin
  assign edge_event_out = edge_rise_in ? (edge_pin_in & ~pin_prev_ff)
                                       : (~edge_pin_in & pin_prev_ff);
  // output-configured pins stay out of the comparison
  assign diff_bits        = (port_pins_in ^ latched_ff) & port_is_input_in;
  assign mismatch_out     = |diff_bits;
  assign port_latched_out = latched_ff;
endmodule

// *** core/mcuic_top.sv ***
module mcuic_top
  import mcuic_pkg::*;
#(
  parameter int PERIPH_N = PERIPH_N_DEF
) (
  input  wire logic                clock_in,
  input  wire logic                rstn_in,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr_in,
  input  wire logic                s_axi_awvalid_in,
  output logic                     s_axi_awready_out,
  input  wire logic [31:0]         s_axi_wdata_in,
  input  wire logic [3:0]          s_axi_wstrb_in,
  input  wire logic                s_axi_wvalid_in,
  output logic                     s_axi_wready_out,
  output logic [1:0]               s_axi_bresp_out,
  output logic                     s_axi_bvalid_out,
  input  wire logic                s_axi_bready_in,
  input  wire logic [7:0]          s_axi_araddr_in,
  input  wire logic                s_axi_arvalid_in,
  output logic                     s_axi_arready_out,
  output logic [31:0]              s_axi_rdata_out,
  output logic [1:0]               s_axi_rresp_out,
  output logic                     s_axi_rvalid_out,
  input  wire logic                s_axi_rready_in,
  // interrupt sources
  input  wire logic                ext_edge_irq_pin_in,
  input  wire logic                timer_zero_ovf_in,
  input  wire logic [PERIPH_N-1:0] periph_req_in,
  input  wire logic [PORT_N-1:0]   port_pins_in,
  input  wire logic [PORT_N-1:0]   port_is_input_in,
  // processor core
  input  wire logic                instr_tick_in,
  input  wire logic [PC_W-1:0]     pc_in,
  input  wire logic                return_from_irq_op_in,
  output logic                     irq_req_out,
  output logic                     vector_take_out,
  output logic [PC_W-1:0]          vector_pc_out,
  output logic                     stack_push_out,
  output logic [PC_W-1:0]          return_addr_out
);
  // elaboration check: sources must fit the documented budget
  if (PERIPH_N < 1 || PERIPH_N + CORE_SRC_N > MAX_SRC_N) begin : g_bad_periph_n
    $error("PERIPH_N out of range");
  end

  logic [7:0]          ctrl_ff;
  logic [PERIPH_N-1:0] pflag_ff;
  logic [PERIPH_N-1:0] pen_ff;
  logic [7:0]          cfg_ff;
  logic                awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic                aw_got_ff, w_got_ff;
  logic [7:0]          awaddr_ff;
  logic [7:0]          wdata_ff;
  logic                wlane_ff;
  logic [1:0]          bresp_ff, rresp_ff;
  logic [31:0]         rdata_ff;
  logic                irq_req_ff, take_ff, push_ff;
  logic [PC_W-1:0]     vec_pc_ff, ret_addr_ff;
  logic [1:0]          tick_cnt_ff;
  mcuic_state_t        state_ff;

  // write decode: both halves captured, response not yet pending
  wire do_write  = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire wr_lane   = do_write & wlane_ff;
  wire wr_ctrl   = wr_lane & (awaddr_ff == OFS_CTRL);
  wire wr_pflag  = wr_lane & (awaddr_ff == OFS_PFLAG);
  wire wr_pen    = wr_lane & (awaddr_ff == OFS_PEN);
  wire wr_port   = do_write & (awaddr_ff == OFS_PORT);
  wire wr_cfg    = wr_lane & (awaddr_ff == OFS_CFG);
  wire wr_mapped = (awaddr_ff == OFS_CTRL) | (awaddr_ff == OFS_PFLAG) |
                   (awaddr_ff == OFS_PEN) | (awaddr_ff == OFS_PORT) |
                   (awaddr_ff == OFS_CFG);
  // read decode
  wire rd_take   = s_axi_arvalid_in & arready_ff;
  wire rd_port   = rd_take & (s_axi_araddr_in == OFS_PORT);
  wire rd_mapped = (s_axi_araddr_in == OFS_CTRL) | (s_axi_araddr_in == OFS_PFLAG) |
                   (s_axi_araddr_in == OFS_PEN) | (s_axi_araddr_in == OFS_PORT) |
                   (s_axi_araddr_in == OFS_CFG);

  // source detection; any port access refreshes the snapshot
  wire              edge_event;
  wire              port_mismatch;
  wire [PORT_N-1:0] port_latched;
  mcuic_src_detect u_src (
    .clock_in         (clock_in),
    .rstn_in          (rstn_in),
    .edge_pin_in      (ext_edge_irq_pin_in),
    .edge_rise_in     (cfg_ff[BIT_EDGE_RISE]),
    .port_pins_in     (port_pins_in),
    .port_is_input_in (port_is_input_in),
    .port_latch_in    (rd_port | wr_port),
    .edge_event_out   (edge_event),
    .mismatch_out     (port_mismatch),
    .port_latched_out (port_latched)
  );

  // request logic from flags and enables
  wire core_hit   = (ctrl_ff[BIT_T0IF] & ctrl_ff[BIT_T0IE]) |
                    (ctrl_ff[BIT_EDGIF] & ctrl_ff[BIT_EDGIE]) |
                    (ctrl_ff[BIT_PCIF] & ctrl_ff[BIT_PCIE]);
  wire periph_hit = ctrl_ff[BIT_GRP_EN] & (|(pflag_ff & pen_ff));
  wire req_now    = ctrl_ff[BIT_GLB_EN] & (core_hit | periph_hit);

  // vectoring: count instruction ticks, not instructions, so length never matters
  wire take_now = (state_ff == ST_WAIT) & req_now & instr_tick_in &
                  (tick_cnt_ff == LAT_TICKS - 2'h1);

  // hardware set events for the core flags; a set beats a same-cycle clear
  wire [2:0] core_set  = {timer_zero_ovf_in, edge_event, port_mismatch};
  wire [7:0] ctrl_base = wr_ctrl ? wdata_ff : ctrl_ff;
  logic [7:0] nxt_ctrl;
  always_comb begin
    nxt_ctrl = ctrl_base;
    nxt_ctrl[BIT_T0IF]  = ctrl_base[BIT_T0IF] | core_set[2];
    nxt_ctrl[BIT_EDGIF] = ctrl_base[BIT_EDGIF] | core_set[1];
    nxt_ctrl[BIT_PCIF]  = ctrl_base[BIT_PCIF] | core_set[0];
    if (take_now) begin
      nxt_ctrl[BIT_GLB_EN] = 1'b0;
    end else if (return_from_irq_op_in) begin
      nxt_ctrl[BIT_GLB_EN] = 1'b1;
    end
  end

  // peripheral flags, one per source, set wins over software clear
  logic [PERIPH_N-1:0] nxt_pflag;
  for (genvar i = 0; i < PERIPH_N; i++) begin : g_pflag
    assign nxt_pflag[i] = (wr_pflag ? wdata_ff[i] : pflag_ff[i]) | periph_req_in[i];
  end

  // control, flag and enable registers
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_ff  <= RST_CTRL;
      pflag_ff <= '0;
      pen_ff   <= '0;
      cfg_ff   <= RST_CFG;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      pflag_ff <= nxt_pflag;
      if (wr_pen) begin
        pen_ff <= wdata_ff[PERIPH_N-1:0];
      end
      if (wr_cfg) begin
        cfg_ff <= wdata_ff;
      end
    end
  end

  // vectoring state: a dropped request abandons the wait
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff    <= ST_IDLE;
      tick_cnt_ff <= 2'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          tick_cnt_ff <= 2'h0;
          if (req_now) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!req_now || take_now) begin
            state_ff    <= ST_IDLE;
            tick_cnt_ff <= 2'h0;
          end else if (instr_tick_in) begin
            tick_cnt_ff <= tick_cnt_ff + 2'h1;
          end
        end
        default: begin
          state_ff    <= ST_IDLE;
          tick_cnt_ff <= 2'h0;
        end
      endcase
    end
  end

  // core-facing outputs, registered
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_req_ff  <= 1'b0;
      take_ff     <= 1'b0;
      push_ff     <= 1'b0;
      vec_pc_ff   <= '0;
      ret_addr_ff <= '0;
    end else begin
      irq_req_ff <= req_now;
      take_ff    <= take_now;
      push_ff    <= take_now;
      if (take_now) begin
        vec_pc_ff   <= IRQ_VECTOR;
        ret_addr_ff <= pc_in;
      end
    end
  end

  // bus write side: address and data taken in either order
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 8'h00;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && awready_ff) begin
        awready_ff <= 1'b0;
        aw_got_ff  <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr_in[7:2], 2'b00};
      end
      if (s_axi_wvalid_in && wready_ff) begin
        wready_ff <= 1'b0;
        w_got_ff  <= 1'b1;
        wdata_ff  <= s_axi_wdata_in[7:0];
        wlane_ff  <= s_axi_wstrb_in[0];  // only the low lane holds bits
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready_in) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // read mux; narrow registers read zero above their bits
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    case ({s_axi_araddr_in[7:2], 2'b00})
      OFS_CTRL:  rd_data[7:0]          = ctrl_ff;
      OFS_PFLAG: rd_data[PERIPH_N-1:0] = pflag_ff;
      OFS_PEN:   rd_data[PERIPH_N-1:0] = pen_ff;
      OFS_PORT:  rd_data[PORT_N-1:0]   = port_pins_in;
      OFS_CFG:   rd_data[7:0]          = cfg_ff;
      default:   rd_data = 32'h0000_0000;
    endcase
  end

  // bus read side: one read outstanding
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else if (rd_take) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_data;
      rresp_ff   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready_in) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out  = wready_ff;
  assign s_axi_bvalid_out  = bvalid_ff;
  assign s_axi_bresp_out   = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out  = rvalid_ff;
  assign s_axi_rdata_out   = rdata_ff;
  assign s_axi_rresp_out   = rresp_ff;
  assign irq_req_out       = irq_req_ff;
  assign vector_take_out   = take_ff;
  assign vector_pc_out     = vec_pc_ff;
  assign stack_push_out    = push_ff;
  assign return_addr_out   = ret_addr_ff;

  // checks on the vectoring and flag logic
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  take_clears_en_a: assert property (take_ff |-> !ctrl_ff[BIT_GLB_EN])
    else $error("global enable still set after vectoring");
  take_vector_a: assert property (take_ff |-> vec_pc_ff == IRQ_VECTOR && push_ff)
    else $error("vector address or push missing");
  take_needs_en_a: assert property
    (take_ff |-> $past(ctrl_ff[BIT_GLB_EN]) && $past(irq_req_ff))
    else $error("vectored without global enable");
  return_sets_en_a: assert property
    (return_from_irq_op_in && !take_now |=> ctrl_ff[BIT_GLB_EN])
    else $error("return did not restore global enable");
  port_change_flag_a: assert property (port_mismatch |=> ctrl_ff[BIT_PCIF])
    else $error("port change flag not set");
  timer_flag_set_a: assert property (timer_zero_ovf_in |=> ctrl_ff[BIT_T0IF])
    else $error("timer flag not set");
  periph_flag_set_a: assert property (periph_req_in[0] |=> pflag_ff[0])
    else $error("peripheral flag not set");
  core_req_out_a: assert property
    (ctrl_ff[BIT_GLB_EN] && ctrl_ff[BIT_T0IF] && ctrl_ff[BIT_T0IE] |=> irq_req_ff)
    else $error("enabled core flag gave no request");
  latency_take_a: assert property
    (state_ff == ST_WAIT && req_now && instr_tick_in && tick_cnt_ff == 2'h2 |=> take_ff)
    else $error("vectoring missed its tick");
  no_early_take_a: assert property ($rose(state_ff == ST_WAIT) |-> !take_ff [*2])
    else $error("vectored too early");

  cover_take_c:   cover property (take_ff);
  cover_return_c: cover property (take_ff ##[1:200] (return_from_irq_op_in && !take_now));
  cover_port_c:   cover property (rd_port ##1 !port_mismatch);
  cover_write_c:  cover property (bvalid_ff && s_axi_bready_in);
endmodule

// *** dv/mcuic_core_model.sv ***
module mcuic_core_model
  import mcuic_pkg::*;
(
  input  wire logic            clock_in,
  input  wire logic            rstn_in,
  input  wire logic            slow_in,
  input  wire logic [PC_W-1:0] spin_pc_in,
  input  wire logic            ret_req_in,
  input  wire logic            vector_take_in,
  input  wire logic [PC_W-1:0] vector_pc_in,
  output logic                 instr_tick_out,
  output logic [PC_W-1:0]      pc_out,
  output logic                 return_op_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]      div_ff;
  logic            in_isr_ff;
  logic [PC_W-1:0] isr_pc_ff;
  // one tick per instruction cycle; slow mode stretches the cycle
  assign instr_tick_out = slow_in ? (div_ff == 2'h3) : div_ff[0];
  // spinning on one address keeps the return address known
  assign pc_out = in_isr_ff ? isr_pc_ff : spin_pc_in;
  // jump on take, run the routine, leave on request
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_ff <= 2'h0;
      in_isr_ff <= 1'b0;
      isr_pc_ff <= '0;
      return_op_out <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'h1;
      return_op_out <= 1'b0;
      if (vector_take_in) begin
        in_isr_ff <= 1'b1;
        isr_pc_ff <= vector_pc_in;
      end else if (ret_req_in && in_isr_ff) begin
        in_isr_ff <= 1'b0;
        return_op_out <= 1'b1;
      end else if (instr_tick_out && in_isr_ff) begin
        isr_pc_ff <= isr_pc_ff + 13'h1;
      end
    end
  end
endmodule

// *** dv/tb_mcu_interrupt_control.sv ***
module tb_mcu_interrupt_control
  import mcuic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PN = PERIPH_N_DEF;
  localparam logic [31:0] GLB_EN = 32'h1 << BIT_GLB_EN;
  localparam logic [31:0] GRP_EN = 32'h1 << BIT_GRP_EN;
  localparam logic [31:0] T0IE = 32'h1 << BIT_T0IE;
  localparam logic [31:0] EDGIE = 32'h1 << BIT_EDGIE;
  localparam logic [31:0] PCIE = 32'h1 << BIT_PCIE;
  localparam logic [31:0] T0IF = 32'h1 << BIT_T0IF;
  localparam logic [31:0] EDGIF = 32'h1 << BIT_EDGIF;
  logic            clock_in = 1'b0;
  logic            rstn_in = 1'b0;
  logic [7:0]      awaddr = 8'h0;
  logic [7:0]      araddr = 8'h0;
  logic [31:0]     wdata = 32'h0;
  logic [3:0]      wstrb = 4'h0;
  logic [3:0]      strb = 4'hf;
  logic            awvalid = 1'b0;
  logic            wvalid = 1'b0;
  logic            bready = 1'b0;
  logic            arvalid = 1'b0;
  logic            rready = 1'b0;
  logic            edge_pin = 1'b0;
  logic            tovf = 1'b0;
  logic            slow = 1'b0;
  logic            ret_req = 1'b0;
  logic [PN-1:0]   preq = '0;
  logic [3:0]      pins = 4'h5;
  logic [3:0]      is_in = 4'h0;
  logic [12:0]     spin = 13'h123;
  wire             awready, wready, bvalid, arready, rvalid, irq_req, take, push, tick, retop;
  wire [1:0]       bresp, rresp;
  wire [31:0]      rdata;
  wire [12:0]      vpc, raddr, pc;
  int              mismatches = 0;
  int              check_count = 0;
  int              cyc = 0;
  integer          seed = 32'h1df2;
  logic [31:0]     m;
  time             tev;
  int              dt;
  int              per;
  logic [33:0]     rd_q[$];
  logic [1:0]      wr_q[$];
  logic [12:0]     tk_ret[$];
  time             tk_t[$];

  always #5 clock_in = ~clock_in;

  mcuic_top #(.PERIPH_N(PN)) u_dut (
    .clock_in(clock_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .ext_edge_irq_pin_in(edge_pin), .timer_zero_ovf_in(tovf), .periph_req_in(preq),
    .port_pins_in(pins), .port_is_input_in(is_in), .instr_tick_in(tick), .pc_in(pc),
    .return_from_irq_op_in(retop), .irq_req_out(irq_req), .vector_take_out(take),
    .vector_pc_out(vpc), .stack_push_out(push), .return_addr_out(raddr));

  mcuic_core_model u_core (
    .clock_in(clock_in), .rstn_in(rstn_in), .slow_in(slow), .spin_pc_in(spin),
    .ret_req_in(ret_req), .vector_take_in(take), .vector_pc_in(vpc),
    .instr_tick_out(tick), .pc_out(pc), .return_op_out(retop));

  task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_core(input logic [12:0] got, input logic [12:0] exp);
    chk_bus({21'h0, got}, {21'h0, exp});
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge clock_in);
    wr_q.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock_in);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clock_in);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock_in);
    rd_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_in); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock_in); while (!rvalid);
    rready <= 1'b0;
  endtask

  // latency is only judged for external events
  task automatic expect_take(input bit lat);
    tk_ret.push_back(spin);
    tk_t.push_back(lat ? $time : 0);
  endtask

  task automatic wait_take;
    while (tk_ret.size() != 0) @(posedge clock_in);
  endtask

  task automatic ret;
    @(posedge clock_in);
    ret_req <= 1'b1;
    @(posedge clock_in);
    ret_req <= 1'b0;
  endtask

  // monitor: every result takes the oldest note off its queue
  always @(posedge clock_in) begin
    cyc++;
    if (bvalid && bready) chk_bus({32'h0, bresp}, {32'h0, wr_q.pop_front()});
    if (rvalid && rready) chk_bus({rresp, rdata}, rd_q.pop_front());
    if (take && tk_ret.size() == 0) chk_core(13'h1, 13'h0);
    else if (take) begin
      chk_core(vpc, IRQ_VECTOR);
      chk_core({12'h0, push}, 13'h1);
      chk_core({12'h0, irq_req}, 13'h1);
      chk_core(raddr, tk_ret.pop_front());
      tev = tk_t.pop_front();
      per = slow ? 4 : 2;
      dt = int'(($time - tev) / 10);
      if (tev != 0) chk_core({12'h0, dt >= 3 * per && dt <= 4 * per + 4}, 13'h1);
    end
    // ceiling checked last so nothing in this process follows the finish
    if (cyc > 20000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge clock_in);
    rstn_in <= 1'b1;
    rd(OFS_CTRL, {24'h0, RST_CTRL}, RESP_OKAY);
    rd(OFS_PFLAG, 32'h0, RESP_OKAY);
    rd(OFS_PEN, 32'h0, RESP_OKAY);
    rd(OFS_CFG, {24'h0, RST_CFG}, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h5a, RESP_SLVERR);
    // low lane strobe off: answered but the register keeps its value
    strb = 4'he;
    wr(OFS_PEN, 32'h3f, RESP_OKAY);
    strb = 4'hf;
    rd(OFS_PEN, 32'h0, RESP_OKAY);
    $display("test registers done");
    // timer flag sets while masked, then unmasking takes at once
    wr(OFS_CTRL, GLB_EN, RESP_OKAY);
    tovf <= 1'b1;
    @(posedge clock_in);
    tovf <= 1'b0;
    repeat (20) @(posedge clock_in);
    rd(OFS_CTRL, GLB_EN | T0IF, RESP_OKAY);
    expect_take(0);
    wr(OFS_CTRL, GLB_EN | T0IE | T0IF, RESP_OKAY);
    wait_take();
    rd(OFS_CTRL, T0IE | T0IF, RESP_OKAY);
    // returning with the flag still set re-enters at once
    expect_take(0);
    ret();
    wait_take();
    wr(OFS_CTRL, T0IE, RESP_OKAY);
    ret();
    rd(OFS_CTRL, GLB_EN | T0IE, RESP_OKAY);
    // mid-run reset must drop the global enable again
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    rd(OFS_CTRL, {24'h0, RST_CTRL}, RESP_OKAY);
    $display("test timer done");
    // both pin polarities, fast and slow instruction cycles
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      slow <= k[0];
      edge_pin <= k[0];
      spin <= 13'($random(seed));
      wr(OFS_CFG, {31'h0, ~k[0]}, RESP_OKAY);
      wr(OFS_CTRL, GLB_EN | EDGIE, RESP_OKAY);
      expect_take(1);
      edge_pin <= ~k[0];
      wait_take();
      rd(OFS_CTRL, EDGIE | EDGIF, RESP_OKAY);
      wr(OFS_CTRL, EDGIE, RESP_OKAY);
      ret();
    end
    $display("test edge pin done");
    // random peripheral requests, one source enabled at a time
    for (int i = 0; i < PN; i++) begin
      m = (32'($random(seed)) & ((32'h1 << PN) - 32'h1)) | (32'h1 << i);
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      wr(OFS_PEN, 32'h1 << i, RESP_OKAY);
      wr(OFS_PFLAG, 32'h0, RESP_OKAY);
      wr(OFS_CTRL, GLB_EN, RESP_OKAY);
      preq <= m[PN-1:0];
      @(posedge clock_in);
      preq <= '0;
      repeat (12) @(posedge clock_in);
      rd(OFS_PFLAG, m, RESP_OKAY);
      expect_take(0);
      wr(OFS_CTRL, GLB_EN | GRP_EN, RESP_OKAY);
      wait_take();
      wr(OFS_PFLAG, 32'h0, RESP_OKAY);
      ret();
    end
    $display("test peripherals done");
    // port change: output pins ignored, input pin mismatch flags
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    is_in <= (4'($random(seed)) & 4'h7) | 4'h1;
    wr(OFS_PORT, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, GLB_EN | PCIE, RESP_OKAY);
    pins <= pins ^ 4'h8;
    repeat (12) @(posedge clock_in);
    rd(OFS_CTRL, GLB_EN | PCIE, RESP_OKAY);
    expect_take(1);
    pins <= pins ^ 4'h1;
    wait_take();
    rd(OFS_PORT, {28'h0, pins}, RESP_OKAY);
    wr(OFS_PORT, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, PCIE, RESP_OKAY);
    rd(OFS_CTRL, PCIE, RESP_OKAY);
    $display("test port change done");
    repeat (4) @(posedge clock_in);
    summarize();
  end
endmodule
